// ==== logic/mcuex_pkg.sv ====
// Shared constants, opcodes and carrier types for the execute unit
package mcuex_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] REG_CMD      = 8'h00;
    localparam logic [7:0] REG_ACCU     = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_PC       = 8'h0c;
    localparam logic [7:0] REG_MEM_IDX  = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    // Status bit positions
    localparam int ST_C   = 0;
    localparam int ST_HC  = 1;
    localparam int ST_Z   = 2;
    localparam int ST_SV  = 3;
    localparam int ST_PWD = 4;
    localparam int ST_TMO = 5;
    // Reset values and parameter defaults
    localparam logic [7:0] ACCU_RST   = 8'h00;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam int         PC_W_DEF   = 12;
    localparam int         DM_DEF     = 64;
    // Data memory address that aliases the program counter low byte
    localparam logic [7:0] PCLO_MADDR = 8'h02;
    // Decimal adjust figures
    localparam logic [3:0] BCD_MAX    = 4'h9;
    localparam logic [3:0] BCD_FIX    = 4'h6;

    typedef enum logic [4:0] {
        OP_NOP      = 5'h00, OP_ADD_AM  = 5'h01, OP_ADD_AX  = 5'h02,
        OP_ADD_TM   = 5'h03, OP_ADC_AM  = 5'h04, OP_ADC_TM  = 5'h05,
        OP_AND_AM   = 5'h06, OP_AND_AX  = 5'h07, OP_AND_TM  = 5'h08,
        OP_OR_AM    = 5'h09, OP_OR_AX   = 5'h0a, OP_OR_TM   = 5'h0b,
        OP_CPL      = 5'h0c, OP_CPL_TA  = 5'h0d, OP_INC     = 5'h0e,
        OP_INC_TA   = 5'h0f, OP_DEC     = 5'h10, OP_DEC_TA  = 5'h11,
        OP_BCD_ADJ  = 5'h12, OP_MOV_AM  = 5'h13, OP_MOV_AX  = 5'h14,
        OP_MOV_MA   = 5'h15, OP_CLR_M   = 5'h16, OP_CLR_BIT = 5'h17,
        OP_CALL     = 5'h18, OP_JMP     = 5'h19, OP_RET     = 5'h1a,
        OP_DOG_CLR  = 5'h1b, OP_DOG_PRE1 = 5'h1c, OP_DOG_PRE2 = 5'h1d,
        OP_HALT     = 5'h1e, OP_SPARE   = 5'h1f
    } mcuex_op_t;

    // Command word written to REG_CMD
    typedef struct packed {
        logic [15:0] operand;
        logic [7:0]  maddr;
        logic [2:0]  bitsel;
        mcuex_op_t   op;
    } mcuex_cmd_t;

    // Arithmetic result with its flags
    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       hc;
        logic       sv;
    } mcuex_alu_t;
endpackage : mcuex_pkg

// ==== logic/mcuex_core.sv ====
// Instruction execute unit: ALU, flags, program counter and data memory
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
module mcuex_core
    import mcuex_pkg::*;
#(
    parameter int PC_W     = PC_W_DEF,
    parameter int DM_WORDS = DM_DEF
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    output logic                 stack_push,
    output logic [PC_W-1:0]      stack_push_pc,
    output logic                 stack_pop,
    input  wire logic [PC_W-1:0] stack_top,
    input  wire logic            dog_timeout,
    output logic                 dog_clear,
    output logic                 clock_stop_req,
    input  wire logic            wake_pin
);
    localparam int AW = $clog2(DM_WORDS);

    typedef enum logic [1:0] {S_IDLE, S_DUMMY, S_HALTED} mcuex_state_t;

    mcuex_state_t     state;
    logic [7:0]       accumulator_reg;
    logic             carry_flag;
    logic             aux_carry_flag;
    logic             zero_flag;
    logic             overflow_flag;
    logic             power_down_flag;
    logic             watchdog_timeout_flag;
    logic [PC_W-1:0]  pc;
    logic [7:0]       dmem [DM_WORDS];
    logic [AW-1:0]    mem_idx;
    mcuex_cmd_t       cmd_reg;
    logic             pre_first_seen;
    logic             pre_second_seen;
    logic             wake_meta;
    logic             wake_sync;

    mcuex_cmd_t       cmd_in;
    logic             cmd_wr;
    logic             fire;
    logic             two_cycle;
    logic [7:0]       m_val;
    logic [7:0]       x_val;
    logic [7:0]       b_val;
    logic             cin;
    mcuex_alu_t       sum;
    logic [7:0]       res;
    logic             acc_we;
    logic             mem_we;
    logic             z_we;
    logic             add_we;
    logic             c_we;
    logic             c_new;
    logic             pclo_hit;
    logic             dog_pair;
    logic             dog_hit;
    logic [4:0]       nib_lo;
    logic             daa_lo;
    logic             daa_hi;

    // Byte-enable merge of a write onto the old register value
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Bus decode; the master holds the command word through the dummy cycle
    assign cmd_wr  = avs_write && (avs_address == REG_CMD);
    assign cmd_in  = mcuex_cmd_t'(be_merge(cmd_reg, avs_writedata, avs_byteenable));
    assign pclo_hit = (cmd_in.maddr == PCLO_MADDR);
    assign x_val    = cmd_in.operand[7:0];
    assign m_val    = pclo_hit ? pc[7:0] : dmem[cmd_in.maddr[AW-1:0]];

    // Ops that load the program counter need a second cycle
    always_comb begin
        two_cycle = (cmd_in.op == OP_CALL) || (cmd_in.op == OP_JMP)
                 || (cmd_in.op == OP_RET);
        if (mem_we && pclo_hit) begin
            two_cycle = 1'b1;
        end
    end

    // Stall the first cycle of a two-cycle op and all commands while halted
    always_comb begin
        avs_waitrequest = 1'b0;
        if (cmd_wr && (state == S_HALTED)) begin
            avs_waitrequest = 1'b1;
        end else if (cmd_wr && (state == S_IDLE) && two_cycle) begin
            avs_waitrequest = 1'b1;
        end
    end

    assign fire = cmd_wr && !avs_waitrequest;

    // Adder operand selection and 8-bit sum with carries from bits 3 and 7
    always_comb begin
        b_val = (cmd_in.op == OP_ADD_AX) ? x_val : m_val;
        cin   = 1'b0;
        if ((cmd_in.op == OP_ADC_AM) || (cmd_in.op == OP_ADC_TM)) begin
            cin = carry_flag;
        end
        nib_lo = {1'b0, accumulator_reg[3:0]} + {1'b0, b_val[3:0]} + {4'h0, cin};
        {sum.c, sum.res} = {1'b0, accumulator_reg} + {1'b0, b_val} + {8'h00, cin};
        sum.hc = nib_lo[4];
        sum.sv = (accumulator_reg[7] == b_val[7])
              && (sum.res[7] != accumulator_reg[7]);
    end

    // Decimal adjust nibble tests
    assign daa_lo = (accumulator_reg[3:0] > BCD_MAX) || aux_carry_flag;
    assign daa_hi = (accumulator_reg[7:4] > BCD_MAX) || carry_flag;

    // Per-op result, destination and flag enables
    always_comb begin
        res    = 8'h00;
        acc_we = 1'b0;
        mem_we = 1'b0;
        z_we   = 1'b0;
        add_we = 1'b0;
        c_we   = 1'b0;
        c_new  = carry_flag;
        unique case (cmd_in.op)
            OP_ADD_AM, OP_ADD_AX, OP_ADC_AM: begin
                res    = sum.res;
                acc_we = 1'b1;
                add_we = 1'b1;
            end
            OP_ADD_TM, OP_ADC_TM: begin
                res    = sum.res;
                mem_we = 1'b1;
                add_we = 1'b1;
            end
            OP_AND_AM, OP_AND_AX: begin
                res    = accumulator_reg & ((cmd_in.op == OP_AND_AX) ? x_val : m_val);
                acc_we = 1'b1;
                z_we   = 1'b1;
            end
            OP_AND_TM: begin
                res    = accumulator_reg & m_val;
                mem_we = 1'b1;
                z_we   = 1'b1;
            end
            OP_OR_AM, OP_OR_AX: begin
                res    = accumulator_reg | ((cmd_in.op == OP_OR_AX) ? x_val : m_val);
                acc_we = 1'b1;
                z_we   = 1'b1;
            end
            OP_OR_TM: begin
                res    = accumulator_reg | m_val;
                mem_we = 1'b1;
                z_we   = 1'b1;
            end
            OP_CPL, OP_CPL_TA: begin
                res    = ~m_val;
                acc_we = (cmd_in.op == OP_CPL_TA);
                mem_we = (cmd_in.op == OP_CPL);
                z_we   = 1'b1;
            end
            OP_INC, OP_INC_TA: begin
                res    = m_val + 8'h01;
                acc_we = (cmd_in.op == OP_INC_TA);
                mem_we = (cmd_in.op == OP_INC);
                z_we   = 1'b1;
            end
            OP_DEC, OP_DEC_TA: begin
                res    = m_val - 8'h01;
                acc_we = (cmd_in.op == OP_DEC_TA);
                mem_we = (cmd_in.op == OP_DEC);
                z_we   = 1'b1;
            end
            OP_BCD_ADJ: begin
                res    = accumulator_reg + {daa_hi ? BCD_FIX : 4'h0,
                                            daa_lo ? BCD_FIX : 4'h0};
                mem_we = 1'b1;
                c_we   = 1'b1;
                c_new  = daa_hi;
            end
            OP_MOV_AM, OP_MOV_AX: begin
                res    = (cmd_in.op == OP_MOV_AX) ? x_val : m_val;
                acc_we = 1'b1;
            end
            OP_MOV_MA: begin
                res    = accumulator_reg;
                mem_we = 1'b1;
            end
            OP_CLR_M: begin
                res    = 8'h00;
                mem_we = 1'b1;
            end
            OP_CLR_BIT: begin
                res    = m_val;
                res[cmd_in.bitsel] = 1'b0;
                mem_we = 1'b1;
            end
            default: begin
                res    = 8'h00;
            end
        endcase
    end

    // A pre-clear counts only when the other one was the last seen
    assign dog_pair = ((cmd_in.op == OP_DOG_PRE1) && pre_second_seen)
                   || ((cmd_in.op == OP_DOG_PRE2) && pre_first_seen);
    assign dog_hit  = fire && ((cmd_in.op == OP_DOG_CLR) || dog_pair);

    // Sequencer: dummy cycle for branches, halted until a wake arrives
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (cmd_wr && two_cycle) begin
                        state <= S_DUMMY;
                    end else if (fire && (cmd_in.op == OP_HALT)) begin
                        state <= S_HALTED;
                    end
                end
                S_DUMMY: begin
                    state <= S_IDLE;
                end
                S_HALTED: begin
                    if (wake_sync) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Wake pin comes from outside this clock domain
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_pin;
            wake_sync <= wake_meta;
        end
    end

    // Accumulator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_reg <= ACCU_RST;
        end else if (fire && acc_we) begin
            accumulator_reg <= res;
        end else if (avs_write && (avs_address == REG_ACCU) && avs_byteenable[0]) begin
            accumulator_reg <= avs_writedata[7:0];
        end
    end

    // Arithmetic flags; ops not listed leave them alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {overflow_flag, zero_flag, aux_carry_flag, carry_flag} <= STATUS_RST[3:0];
        end else if (fire && add_we) begin
            carry_flag     <= sum.c;
            aux_carry_flag <= sum.hc;
            overflow_flag  <= sum.sv;
            zero_flag      <= (sum.res == 8'h00);
        end else if (fire && z_we) begin
            zero_flag      <= (res == 8'h00);
        end else if (fire && c_we) begin
            carry_flag     <= c_new;
        end else if (avs_write && (avs_address == REG_STATUS) && avs_byteenable[0]) begin
            carry_flag     <= avs_writedata[ST_C];
            aux_carry_flag <= avs_writedata[ST_HC];
            zero_flag      <= avs_writedata[ST_Z];
            overflow_flag  <= avs_writedata[ST_SV];
        end
    end

    // Power-down and timeout flags; a watchdog time-out wins over a clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            power_down_flag       <= STATUS_RST[ST_PWD];
            watchdog_timeout_flag <= STATUS_RST[ST_TMO];
        end else begin
            if (fire && (cmd_in.op == OP_HALT)) begin
                power_down_flag <= 1'b1;
            end else if (dog_hit) begin
                power_down_flag <= 1'b0;
            end
            if (dog_timeout) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (dog_hit || (fire && (cmd_in.op == OP_HALT))) begin
                watchdog_timeout_flag <= 1'b0;
            end
        end
    end

    // Pre-clear pairing memory; a completed pair starts over
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_first_seen  <= 1'b0;
            pre_second_seen <= 1'b0;
        end else if (fire && ((cmd_in.op == OP_DOG_PRE1) || (cmd_in.op == OP_DOG_PRE2))) begin
            pre_first_seen  <= !dog_pair && (cmd_in.op == OP_DOG_PRE1);
            pre_second_seen <= !dog_pair && (cmd_in.op == OP_DOG_PRE2);
        end
    end

    // Program counter: branches, PC-low writes, else advance by one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc <= '0;
        end else if (fire) begin
            if ((cmd_in.op == OP_CALL) || (cmd_in.op == OP_JMP)) begin
                pc <= cmd_in.operand[PC_W-1:0];
            end else if (cmd_in.op == OP_RET) begin
                pc <= stack_top;
            end else if (mem_we && pclo_hit) begin
                pc[7:0] <= res;
            end else begin
                pc <= pc + PC_W'(1);
            end
        end else if (avs_write && (avs_address == REG_PC)) begin
            pc <= PC_W'(be_merge(32'(pc), avs_writedata, avs_byteenable));
        end
    end

    // Data memory; held intact through power down
    always_ff @(posedge clk_sys) begin
        if (fire && mem_we && !pclo_hit) begin
            dmem[cmd_in.maddr[AW-1:0]] <= res;
        end else if (avs_write && (avs_address == REG_MEM_DATA) && avs_byteenable[0]) begin
            dmem[mem_idx] <= avs_writedata[7:0];
        end
    end

    // Software side registers: memory index and last command word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_idx <= '0;
            cmd_reg <= '0;
        end else begin
            if (avs_write && (avs_address == REG_MEM_IDX)) begin
                mem_idx <= avs_writedata[AW-1:0];
            end
            if (fire) begin
                cmd_reg <= cmd_in;
            end
        end
    end

    // Strobes to the stack, watchdog and clock generator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stack_push     <= 1'b0;
            stack_push_pc  <= '0;
            stack_pop      <= 1'b0;
            dog_clear      <= 1'b0;
            clock_stop_req <= 1'b0;
        end else begin
            stack_push <= fire && (cmd_in.op == OP_CALL);
            stack_pop  <= fire && (cmd_in.op == OP_RET);
            dog_clear  <= dog_hit || (fire && (cmd_in.op == OP_HALT));
            if (fire && (cmd_in.op == OP_CALL)) begin
                stack_push_pc <= pc + PC_W'(1);
            end
            if (fire && (cmd_in.op == OP_HALT)) begin
                clock_stop_req <= 1'b1;
            end else if (wake_sync) begin
                clock_stop_req <= 1'b0;
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        avs_readdata = 32'h0000_0000;
        if (avs_read) begin
            unique case (avs_address)
                REG_CMD:      avs_readdata = cmd_reg;
                REG_ACCU:     avs_readdata = {24'h0, accumulator_reg};
                REG_STATUS:   avs_readdata = {26'h0, watchdog_timeout_flag,
                                              power_down_flag, overflow_flag,
                                              zero_flag, aux_carry_flag, carry_flag};
                REG_PC:       avs_readdata = 32'(pc);
                REG_MEM_IDX:  avs_readdata = 32'(mem_idx);
                REG_MEM_DATA: avs_readdata = {24'h0, dmem[mem_idx]};
                default:      avs_readdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : mcuex_core

// ==== testbench/mcuex_assertions.sv ====
// Port-level timing checks for the execute unit
module mcuex_chk
    import mcuex_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        stack_push,
    input wire logic        stack_pop,
    input wire logic        dog_clear,
    input wire logic        clock_stop_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic       cmd_wr;
    logic       cmd_go;
    logic       brq;
    logic [4:0] op;
    // Only whole command words count, partial lanes merge instead
    assign cmd_wr = avs_write && avs_address == REG_CMD && avs_byteenable == 4'hf;
    assign cmd_go = cmd_wr && !avs_waitrequest;
    assign op     = avs_writedata[4:0];
    assign brq    = cmd_wr && op inside {OP_CALL, OP_JMP, OP_RET};
    a_branch_waits: assert property (brq && !$past(brq) && !clock_stop_req
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("branch did not wait one cycle");
    a_fast_ops: assert property (cmd_wr && !clock_stop_req && op < OP_CALL
        && avs_writedata[15:8] != PCLO_MADDR |-> !avs_waitrequest) else $error("one-cycle op waited");
    a_call_push: assert property (cmd_go && op == OP_CALL |=> stack_push)
        else $error("call gave no push");
    a_push_cause: assert property (stack_push |-> $past(cmd_go) && $past(op) == OP_CALL)
        else $error("push without call");
    a_ret_pop: assert property (cmd_go && op == OP_RET |=> stack_pop ##1 !stack_pop)
        else $error("return pop not a single pulse");
    a_halt_stop: assert property (cmd_go && op == OP_HALT |=> clock_stop_req && dog_clear)
        else $error("halt did not stop clock and clear watchdog");
    a_dog_pulse: assert property (cmd_go && op == OP_DOG_CLR |=> dog_clear)
        else $error("watchdog clear missing");
    a_clear_cause: assert property (dog_clear |-> $past(cmd_go)
        && $past(op) inside {OP_DOG_CLR, OP_DOG_PRE1, OP_DOG_PRE2, OP_HALT})
        else $error("watchdog clear without cause");
endmodule : mcuex_chk
bind mcuex_core mcuex_chk #(.PC_W(PC_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .stack_push(stack_push), .stack_pop(stack_pop), .dog_clear(dog_clear),
    .clock_stop_req(clock_stop_req));

// ==== testbench/tb.sv ====
// Self-checking bench with an integer model of the execute unit
module tb import mcuex_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, dog_timeout = 0;
    logic        wake_pin = 0;
    logic [7:0]  avs_address = 0;
    logic [3:0]  avs_byteenable = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [11:0] stack_top = 0, stack_push_pc;
    logic        avs_waitrequest, stack_push, stack_pop, dog_clear, clock_stop_req;
    int          fails = 0, tests_run = 0, npush = 0, npop = 0, nclr = 0, lastpush = 0;
    int          mA, mc, mac, mz, mov, mpdf, mto, mpc, pre, xpush, xpop, xclr, lastx;
    int          mm[64];
    always #20 clk_sys = ~clk_sys;
    mcuex_core DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .stack_pop(stack_pop), .stack_top(stack_top),
        .dog_timeout(dog_timeout), .dog_clear(dog_clear), .clock_stop_req(clock_stop_req),
        .wake_pin(wake_pin));
    // Count strobes so that a missing or doubled pulse shows up
    always @(posedge clk_sys) begin
        if (stack_push === 1'b1) begin
            npush++;
            lastpush = stack_push_pc;
        end
        if (stack_pop === 1'b1) npop++;
        if (dog_clear === 1'b1) nclr++;
    end
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        n = 0;
        // Waitrequest is looked at mid-cycle, settled for the edge that follows
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        rd = avs_readdata;
        @(posedge clk_sys);
        if (n >= 100) fails++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task verify(input int m);
        int st;
        st = mc | mac << 1 | mz << 2 | mov << 3 | mpdf << 4 | mto << 5;
        bus(0, REG_ACCU, 0, 4'hf);
        chk(rd, mA);
        bus(0, REG_STATUS, 0, 4'hf);
        chk({26'h0, rd[5:0]}, st);
        bus(0, REG_PC, 0, 4'hf);
        chk({20'h0, rd[11:0]}, mpc);
        bus(1, REG_MEM_IDX, m, 4'hf);
        bus(0, REG_MEM_DATA, 0, 4'hf);
        chk({24'h0, rd[7:0]}, mm[m]);
        chk(npush + npop * 256 + nclr * 65536, xpush + xpop * 256 + xclr * 65536);
    endtask : verify
    // Model first, then the command, then compare every visible result
    task ex(input mcuex_op_t op, input int m, input int x);
        int b, r, ci, lo, hi, da, dm;
        b = (op inside {OP_ADD_AX, OP_AND_AX, OP_OR_AX, OP_MOV_AX}) ? x & 255 : mm[m];
        r = 0;
        case (op)
            OP_ADD_AM, OP_ADD_AX, OP_ADD_TM, OP_ADC_AM, OP_ADC_TM: begin
                ci = (op inside {OP_ADC_AM, OP_ADC_TM}) ? mc : 0;
                r = mA + b + ci;
                mc = r >> 8;
                r = r & 255;
                mac = ((mA & 15) + (b & 15) + ci) >> 4;
                mov = ((mA ^ r) & (b ^ r) & 128) >> 7;
            end
            OP_AND_AM, OP_AND_AX, OP_AND_TM: r = mA & b;
            OP_OR_AM, OP_OR_AX, OP_OR_TM: r = mA | b;
            OP_CPL, OP_CPL_TA: r = ~b & 255;
            OP_INC, OP_INC_TA: r = (b + 1) & 255;
            OP_DEC, OP_DEC_TA: r = (b + 255) & 255;
            OP_BCD_ADJ: begin
                lo = (mA & 15) > 9 || mac;
                hi = (mA >> 4) > 9 || mc;
                mm[m] = (mA + lo * 6 + hi * 96) & 255;
                mc = hi;
            end
            OP_MOV_AM, OP_MOV_AX: mA = b;
            OP_MOV_MA: mm[m] = mA;
            OP_CLR_M: mm[m] = 0;
            OP_CLR_BIT: mm[m] = mm[m] & ~(1 << (x & 7));
            OP_CALL: begin
                xpush++;
                lastx = (mpc + 1) & 4095;
            end
            OP_RET: xpop++;
            OP_DOG_CLR, OP_HALT: begin
                xclr++;
                mto = 0;
                mpdf = (op == OP_HALT);
            end
            OP_DOG_PRE1, OP_DOG_PRE2: begin
                if (pre != 0 && pre != op) begin
                    xclr++;
                    mto = 0;
                    mpdf = 0;
                    pre = 0;
                end else pre = op;
            end
            default: ;
        endcase
        da = op inside {OP_ADD_AM, OP_ADD_AX, OP_ADC_AM, OP_AND_AM, OP_AND_AX, OP_OR_AM,
                        OP_OR_AX, OP_CPL_TA, OP_INC_TA, OP_DEC_TA};
        dm = op inside {OP_ADD_TM, OP_ADC_TM, OP_AND_TM, OP_OR_TM, OP_CPL, OP_INC, OP_DEC};
        if (da) mA = r;
        if (dm) mm[m] = r;
        if (da || dm) mz = (r == 0);
        bus(1, REG_CMD, {x[15:0], m[7:0], x[2:0], op}, 4'hf);
        // Return target is sampled at the execute edge, so it is read after the bus cycle
        if (op inside {OP_CALL, OP_JMP}) mpc = x & 4095;
        else if (op == OP_RET) mpc = stack_top;
        else mpc = (mpc + 1) & 4095;
        verify(m);
    endtask : ex
    task tout;
        @(posedge clk_sys);
        dog_timeout <= 1'b1;
        @(posedge clk_sys);
        dog_timeout <= 1'b0;
        mto = 1;
    endtask : tout
    // Watchdog against a hung handshake
    initial begin
        #800000;
        fails++;
        wrap_up;
    end
    initial begin
        void'($urandom(43));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 3; i < 64; i++) begin
            mm[i] = $urandom & 255;
            bus(1, REG_MEM_IDX, i, 4'hf);
            bus(1, REG_MEM_DATA, mm[i], 4'h1);
        end
        verify(3);
        bus(1, REG_ACCU, 32'hff, 4'h0);
        bus(1, 8'h40, 32'h5a, 4'hf);
        bus(0, 8'h40, 0, 4'hf);
        chk(rd, 0);
        verify(3);
        // Decimal carry chain and signed overflow boundaries
        ex(OP_MOV_AX, 3, 8'h99);
        ex(OP_ADD_AX, 3, 8'h99);
        ex(OP_BCD_ADJ, 4, 0);
        ex(OP_ADC_TM, 5, 0);
        ex(OP_MOV_AX, 3, 8'h7f);
        ex(OP_ADD_AX, 3, 8'h01);
        ex(OP_ADD_AX, 3, 8'h80);
        // Pre-clears: a repeat does nothing, the alternate completes the pair
        tout;
        ex(OP_DOG_PRE1, 3, 0);
        ex(OP_DOG_PRE1, 3, 0);
        ex(OP_DOG_PRE2, 3, 0);
        tout;
        ex(OP_DOG_CLR, 3, 0);
        tout;
        ex(OP_HALT, 6, 0);
        chk(clock_stop_req, 1'b1);
        @(posedge clk_sys);
        wake_pin <= 1'b1;
        for (int i = 0; i < 20 && clock_stop_req !== 1'b0; i++) @(posedge clk_sys);
        wake_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(clock_stop_req, 1'b0);
        ex(OP_DOG_CLR, 6, 0);
        repeat (4) begin
            stack_top <= 12'($urandom);
            ex(OP_CALL, 3, $urandom & 4095);
            chk(lastpush, lastx);
            ex(OP_JMP, 3, $urandom & 4095);
            ex(OP_RET, 3, 0);
        end
        repeat (300) ex(mcuex_op_t'($urandom_range(0, 23)), $urandom_range(3, 63), $urandom);
        wrap_up;
    end
endmodule : tb
